/* hw/jump_branch_regs.vh */
`ifndef JUMP_BRANCH_REGS_VH
`define JUMP_BRANCH_REGS_VH

// Program space below 8 kB
`define JB_PROG_BYTES 8192
`define JB_PC_W 13

// Accumulator word
`define JB_ACC_W 24
`define JB_BIT_MAX 5'd23

// Relative offset width, signed bytes
`define JB_OFS_W 8

// Jump kinds on op_kind
`define JB_OP_JUMP 3'h0
`define JB_OP_BIT_CLEAR 3'h1
`define JB_OP_BIT_SET 3'h2
`define JB_OP_CARRY_CLEAR 3'h3
`define JB_OP_CARRY_SET 3'h4

// Accumulator select codes
`define JB_ACC_X 2'h0
`define JB_ACC_Y 2'h1
`define JB_ACC_Z 2'h2
`define JB_ACC_R 2'h3

// Instruction lengths in bytes
`define JB_LEN_REL 2'h2
`define JB_LEN_ABS 2'h3
`define JB_LEN_BIT 2'h3

// Execution cycles
`define JB_CYC_REL 3'h3
`define JB_CYC_ABS 3'h4
`define JB_CYC_BIT 3'h4

`endif

/* hw/jump_branch_unit.v */
// Behaviour
// - Unconditional jump always loads target
// - Program counter covers only 8 kB
// - Relative form 2 bytes, absolute 3
// - Relative form 3 cycles, absolute 4
// - Bit tests pick x/y/z/r and bit 0..23
// - Bit clear jumps on 0; 3 bytes, 4 cycles
// - Bit set jumps on 1; same cost
// - Carry clear jumps when carry is 0
// - Carry set jumps when carry is 1
`include "jump_branch_regs.vh"

module jump_branch_unit (
  input wire sys_clk,
  input wire resetn,
  input wire pc_load,
  input wire [`JB_PC_W-1:0] pc_load_value,
  input wire issue,
  input wire [2:0] op_kind,
  input wire abs_form,
  input wire [`JB_PC_W-1:0] jump_target,
  input wire [1:0] accumulator_select,
  input wire [4:0] bit_index,
  input wire [`JB_ACC_W-1:0] acc_x,
  input wire [`JB_ACC_W-1:0] acc_y,
  input wire [`JB_ACC_W-1:0] acc_z,
  input wire [`JB_ACC_W-1:0] acc_r,
  input wire carry,
  output reg [`JB_PC_W-1:0] pc_q,
  output reg busy_q,
  output reg done_q,
  output reg taken_q,
  output reg reject_q,
  output reg [1:0] instr_len_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the instruction offered on issue

  reg [`JB_ACC_W-1:0] acc_word;
  reg bit_value;
  reg op_valid;
  reg cond_d;
  reg [1:0] len_d;
  reg [2:0] cyc_d;
  reg [`JB_PC_W-1:0] target_d;
  reg [`JB_PC_W-1:0] next_d;
  wire is_bit_op;
  wire use_abs;

  assign is_bit_op = (op_kind == `JB_OP_BIT_CLEAR) || (op_kind == `JB_OP_BIT_SET);
  // Bit tests exist only in the 3-byte form
  assign use_abs = abs_form | is_bit_op;

  always @* begin
    case (accumulator_select)
      `JB_ACC_X: acc_word = acc_x;
      `JB_ACC_Y: acc_word = acc_y;
      `JB_ACC_Z: acc_word = acc_z;
      default: acc_word = acc_r;
    endcase
  end

  always @* begin
    bit_value = 1'b0;
    if (bit_index <= `JB_BIT_MAX) begin
      bit_value = acc_word[bit_index];
    end
  end

  always @* begin
    op_valid = 1'b1;
    case (op_kind)
      `JB_OP_JUMP: cond_d = 1'b1;
      `JB_OP_BIT_CLEAR: cond_d = (bit_value == 1'b0);
      `JB_OP_BIT_SET: cond_d = (bit_value == 1'b1);
      `JB_OP_CARRY_CLEAR: cond_d = (carry == 1'b0);
      `JB_OP_CARRY_SET: cond_d = (carry == 1'b1);
      default: begin
        cond_d = 1'b0;
        op_valid = 1'b0;
      end
    endcase
    // Bit index beyond the 24-bit word is not a legal operand
    if (is_bit_op && (bit_index > `JB_BIT_MAX)) begin
      op_valid = 1'b0;
    end
  end

  always @* begin
    if (is_bit_op) begin
      len_d = `JB_LEN_BIT;
      cyc_d = `JB_CYC_BIT;
    end else if (use_abs) begin
      len_d = `JB_LEN_ABS;
      cyc_d = `JB_CYC_ABS;
    end else begin
      len_d = `JB_LEN_REL;
      cyc_d = `JB_CYC_REL;
    end
  end

  // Addresses wrap inside the 13-bit space
  always @* begin
    if (use_abs) begin
      target_d = jump_target;
    end else begin
      target_d = pc_q + {{(`JB_PC_W-`JB_OFS_W){jump_target[`JB_OFS_W-1]}},
                         jump_target[`JB_OFS_W-1:0]};
    end
    next_d = pc_q + {{(`JB_PC_W-2){1'b0}}, len_d};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution sequence

  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg state_q;
  reg [2:0] cnt_q;
  reg [`JB_PC_W-1:0] dest_q;
  reg cond_q;
  wire idle;
  wire accept;
  wire finish;
  wire last;

  assign idle = (state_q == ST_IDLE);
  // Issue is taken only while idle; a busy unit ignores it
  assign accept = idle && issue && op_valid;
  // Completion cycle carries the program counter update
  assign finish = !idle && (cnt_q == 3'h1);
  assign last = !idle && (cnt_q == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: state and remaining cycles

  // Counter starts at cycles minus one, so busy spans the full cost
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_EXEC;
            cnt_q <= cyc_d - 3'h1;
          end
        end
        ST_EXEC: begin
          if (cnt_q == 3'h0) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outcome captured at issue; later flag changes do not count

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dest_q <= {`JB_PC_W{1'b0}};
      cond_q <= 1'b0;
    end else if (accept) begin
      cond_q <= cond_d;
      if (cond_d) begin
        dest_q <= target_d;
      end else begin
        dest_q <= next_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= {`JB_PC_W{1'b0}};
    end else if (finish) begin
      pc_q <= dest_q;
    end else if (idle && !issue && pc_load) begin
      // Loads are refused while busy or while an issue is offered
      pc_q <= pc_load_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  // Done is a one-cycle pulse; reject stays high for as long as an invalid issue is held while idle
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      taken_q <= 1'b0;
      reject_q <= 1'b0;
      instr_len_q <= 2'h0;
    end else begin
      done_q <= finish;
      reject_q <= idle && issue && !op_valid;
      if (accept) begin
        busy_q <= 1'b1;
        taken_q <= 1'b0;
        instr_len_q <= len_d;
      end else if (finish) begin
        taken_q <= cond_q;
      end else if (last) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule // jump_branch_unit

/* tb/jump_branch_unit_monitor.sv */
module jump_branch_unit_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire issue,
  input wire [2:0] op_kind,
  input wire abs_form,
  input wire [12:0] jump_target,
  input wire [4:0] bit_index,
  input wire carry,
  input wire [12:0] pc_q,
  input wire busy_q,
  input wire done_q,
  input wire taken_q,
  input wire reject_q,
  input wire [1:0] instr_len_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire g = issue && !busy_q;
  wire j0 = g && op_kind == 0;
  wire a4 = g && abs_form;
  wire b = op_kind == 1 || op_kind == 2;
  rel_busy_a: assert property (j0 && !abs_form |=> busy_q [*3] ##1 !busy_q)
    else $error("busy");
  abs_done_a: assert property (j0 && abs_form |=> !done_q [*3] ##1 done_q)
    else $error("done");
  goto_pc_a: assert property (j0 && abs_form |-> ##4 pc_q == $past(jump_target, 4))
    else $error("pc");
  rel_len_a: assert property (g && op_kind == 4 && !abs_form |=> instr_len_q == 2)
    else $error("len");
  bit_len_a: assert property (g && b && bit_index < 24 |=> instr_len_q == 3 ##3 done_q)
    else $error("bit");
  car_set_a: assert property (a4 && op_kind == 4 |-> ##4 taken_q == $past(carry, 4))
    else $error("set");
  car_clr_a: assert property (a4 && op_kind == 3 |-> ##4 taken_q != $past(carry, 4))
    else $error("clr");
  bad_bit_a: assert property (g && b && bit_index > 23 |=> reject_q && !busy_q)
    else $error("rej");
endmodule // jump_branch_unit_monitor

/* tb/test_jump_branch_unit.sv */
module test_jump_branch_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, pc_load = 0, issue = 0, abs_form = 0, carry = 0, b;
  logic [2:0] op_kind = 0;
  logic [12:0] pc_load_value = 0, jump_target = 0, pc_q;
  logic [1:0] accumulator_select = 0, instr_len_q;
  logic [4:0] bit_index = 0;
  logic [23:0] a[4] = '{0, 0, 0, 0};
  logic busy_q, done_q, taken_q, reject_q;
  int err_count = 0, n_compared = 0, cyc = 0, m, ln, cy, tk, i, j;
  int exp_q[$];
  jump_branch_unit u_jump_branch_unit(.sys_clk, .resetn, .pc_load, .pc_load_value, .issue,
    .op_kind, .abs_form, .jump_target, .accumulator_select, .bit_index, .acc_x(a[0]),
    .acc_y(a[1]), .acc_z(a[2]), .acc_r(a[3]), .carry, .pc_q, .busy_q, .done_q, .taken_q,
    .reject_q, .instr_len_q);
  always #2.5 sys_clk = ~sys_clk;
  task chk_pc(input logic [12:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task chk_flag(input logic g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task chk_count(input logic [3:0] g, e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk) if (++cyc > 3000) begin
    err_count++;
    conclude;
  end
  // Second issue cycle lands while busy
  task ex(input int op, ab, h);
    @(negedge sys_clk);
    op_kind = op[2:0];
    abs_form = ab[0];
    {jump_target, carry, accumulator_select} = 16'($urandom);
    bit_index = 5'($urandom % 24);
    foreach (a[k]) a[k] = $urandom;
    issue = 1;
    b = a[accumulator_select][bit_index];
    ln = ab[0] || op == 1 || op == 2 ? 3 : 2;
    cy = ln == 2 ? 3 : 4;
    tk = op == 0 || op == 3 && !carry || op == 4 && carry || op == 1 && !b || op == 2 && b;
    if (!tk) m += ln;
    else if (ln == 2) m += $signed(jump_target[7:0]);
    else m = jump_target;
    m &= 8191;
    exp_q = '{cy, tk, ln};
    // Flags and loads change while busy; the result must not follow them
    @(negedge sys_clk) begin
      issue = h[0];
      carry = ~carry;
      foreach (a[k]) a[k] = ~a[k];
      pc_load = 1;
      pc_load_value = 13'($urandom);
    end
    @(negedge sys_clk) begin
      issue = 0;
      pc_load = 0;
    end
    for (i = 2; done_q !== 1 && i < 9; i++) @(negedge sys_clk);
    chk_count(i, exp_q.pop_front());
    chk_pc(pc_q, m);
    chk_flag(taken_q, exp_q.pop_front());
    chk_count(instr_len_q, exp_q.pop_front());
  endtask
  initial begin
    ln = $urandom(32'h7eeeed6c);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1;
    pc_load = 1;
    pc_load_value = 13'h1ff0;
    @(negedge sys_clk) pc_load = 0;
    m = 13'h1ff0;
    chk_pc(pc_q, m);
    $display("load done");
    for (j = 0; j < 50; j++) ex(j < 10 ? j / 2 : $urandom % 5, j < 10 ? j : $urandom, j % 2);
    $display("jumps done");
    for (j = 0; j < 2; j++) begin
      @(negedge sys_clk) {op_kind, bit_index, issue} = j ? 9'h141 : 9'h071;
      @(negedge sys_clk) issue = 0;
      chk_flag(reject_q, 1'b1);
      chk_flag(busy_q, 1'b0);
      chk_pc(pc_q, m);
    end
    $display("illegal done");
    conclude;
  end
endmodule // test_jump_branch_unit
bind jump_branch_unit jump_branch_unit_monitor u_mon(.sys_clk, .resetn, .issue, .op_kind,
  .abs_form, .jump_target, .bit_index, .carry, .pc_q, .busy_q, .done_q, .taken_q, .reject_q,
  .instr_len_q);
